// File: rtl/mmx_cfg.svh
// Purpose: constants for the move/multiply/or execution block
// Assumes: states counted in clock cycles, one state per cycle
// Notes: opcodes are first bytes after any escape prefix
`ifndef MMX_CFG_SVH
`define MMX_CFG_SVH
`define MMX_OP_NOP 8'h00
`define MMX_OP_ZERO_EXTEND_MOVE 8'h0a
`define MMX_OP_XRD_DP 8'he0
`define MMX_OP_XRD_RI 7'h71
`define MMX_OP_XWR_DP 8'hf0
`define MMX_OP_XWR_RI 7'h79
`define MMX_OP_MULR 8'hac
`define MMX_OP_MULW 8'had
`define MMX_OP_MULAB 8'ha4
`define MMX_OP_OR_DA 8'h42
`define MMX_OP_OR_DI 8'h43
`define MMX_OP_OR_AI 8'h44
`define MMX_OP_OR_AD 8'h45
`define MMX_OP_OR_AR 7'h23
`define MMX_OP_OR_ARN 5'h09
`define MMX_OP_OR_RR 8'h4c
`define MMX_OP_OR_WW 8'h4d
`define MMX_ST_NOP 4'h1
`define MMX_ST_ZERO_EXTEND_MOVE_BIN 4'h2
`define MMX_ST_ZERO_EXTEND_MOVE_SRC 4'h1
`define MMX_ST_XRI 4'h3
`define MMX_ST_XDP 4'h4
`define MMX_ST_MULR_BIN 4'h6
`define MMX_ST_MULR_SRC 4'h5
`define MMX_ST_MULW_BIN 4'hb
`define MMX_ST_MULW_SRC 4'ha
`define MMX_ST_MULAB 4'h5
`define MMX_ST_OR 4'h2
`define MMX_ST_PORT 4'h4
`define MMX_BYTE_MAX 16'h00ff
`define MMX_WORD_MAX 32'h0000_ffff
`define MMX_PORT_LO 8'h80
`define MMX_PORT_HI 8'hb0
`define MMX_PORT_MASK 8'hcf
`endif

// File: rtl/mmx_pkg.sv
// Purpose: types shared by the execution block
// Assumes: nothing
// Notes: constants live in mmx_cfg.svh
package mmx_pkg;
  typedef enum logic [2:0] {
    MMX_IDLE = 3'b001,
    MMX_EXEC = 3'b010,
    MMX_DONE = 3'b100
  } mmx_state_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
    logic prefixed;
  } mmx_instr_s;
  typedef struct packed {
    logic carry_flag;
    logic auxiliary_carry_flag;
    logic overflow_flag;
    logic neg;
    logic zero;
  } mmx_flags_s;
  typedef struct packed {
    logic [7:0] port_zero;
    logic [7:0] port_two;
    logic oe;
    logic wr;
    logic rd;
  } mmx_xbus_s;
endpackage

// File: rtl/mmx_mul.sv
// Purpose: unsigned 16x16 multiply with flag terms
// Assumes: byte operands arrive zero-extended
// Notes: combinational, registered by the caller
`timescale 1ns/1ps
`include "mmx_cfg.svh"
module mmx_mul
  import mmx_pkg::*;
(
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  input wire logic word_i,
  output logic [31:0] prod_o,
  output logic ovf_o,
  output logic neg_o,
  output logic zero_o
);
  always_comb begin
    prod_o = a_i * b_i;
    // RQ9 RQ11 overflow limit
    ovf_o = word_i ? (prod_o > `MMX_WORD_MAX)
                   : (prod_o > {16'h0000, `MMX_BYTE_MAX});
    // RQ14 sign and zero
    neg_o = word_i ? prod_o[31] : prod_o[15];
    zero_o = (prod_o == 32'h0000_0000);
  end
endmodule

// File: rtl/mmx_core.sv
// Purpose: executes external move, zero-extend, multiply, no-op and or
// Assumes: decoder hands one instruction with register operands read
// Notes: one state per clock; a done pulse ends every legal instruction, an illegal opcode pulses illegal instead
// Notes on behaviour
// RQ1: Short external move drives R0 or R1 as byte address on port 0.
// RQ2: Long external move drives data pointer high on port 2, low on 0.
// RQ3: Nonpage mode multiplexes data byte with low address on port 0.
// RQ4: Page mode puts data on port 2, with latch or high address.
// RQ5: Indirect external load is 1110 001i, 3 states, prefixed in source.
// RQ6: Zero-extend copies byte to word low, clears word high byte.
// RQ7: Zero-extend 0000 1010; 2 states binary, 1 state source.
// RQ8: Multiply takes register operands only, both unsigned.
// RQ9: Byte multiply gives 16-bit product, overflow above 255.
// RQ10: Byte product pairs into even/odd registers by destination parity.
// RQ11: Word multiply gives 32-bit product, overflow above ffff.
// RQ12: Word product pairs into word registers by destination index; code writes the low word and bits 23:16 only, dropping bits 31:24.
// RQ13: Every multiply clears carry.
// RQ14: Multiply sets negative from product top bit, zero when zero.
// RQ15: Byte multiply 1010 1100; 6 states binary, 5 source.
// RQ16: Accumulator-by-B multiply: low to accumulator, high to B.
// RQ17: No-operation takes 1 state and only advances program counter.
// RQ18: Writing a port register takes four states.
// RQ19: Or combines operands bitwise, result to destination.
// RQ20: Accumulator and direct destinations accept listed sources.
// RQ21: Or on a port reads the output latch, not pins.
// RQ22: Or updates negative and zero, keeps carry, aux and overflow.
`timescale 1ns/1ps
`include "mmx_cfg.svh"
module mmx_core
  import mmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire mmx_instr_s instr_i,
  input wire logic source_mode_i,
  input wire logic page_mode_i,
  input wire logic [15:0] dst_val_i,
  input wire logic [15:0] src_val_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] b_i,
  input wire logic [7:0] ind_reg_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] port_two_latch_i,
  input wire logic [7:0] port_latch_i,
  input wire logic [7:0] xdata_pin_i,
  input wire mmx_flags_s flags_i,
  output mmx_flags_s flags_o,
  output mmx_xbus_s xbus_o,
  output logic [7:0] wr0_data_o,
  output logic [4:0] wr0_idx_o,
  output logic [15:0] wr1_data_o,
  output logic [4:0] wr1_idx_o,
  output logic [1:0] wr_en_o,
  output logic wr_word_o,
  output logic [7:0] acc_o,
  output logic acc_we_o,
  output logic [7:0] b_o,
  output logic b_we_o,
  output logic [7:0] dir_o,
  output logic dir_we_o,
  output logic pc_inc_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o
);
  mmx_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] len;
  mmx_flags_s flags_reg, flags_next;
  mmx_xbus_s xbus_reg, xbus_next;
  logic [7:0] wr0_data_reg, wr0_data_next;
  logic [4:0] wr0_idx_reg, wr0_idx_next;
  logic [15:0] wr1_data_reg, wr1_data_next;
  logic [4:0] wr1_idx_reg, wr1_idx_next;
  logic [1:0] wr_en_reg, wr_en_next;
  logic wr_word_reg, wr_word_next;
  logic [7:0] acc_reg, acc_next, b_reg, b_next, dir_reg, dir_next;
  logic acc_we_reg, acc_we_next, b_we_reg, b_we_next;
  logic dir_we_reg, dir_we_next, pc_reg, pc_next;
  logic done_reg, done_next, ill_reg, ill_next;
  logic [7:0] xd_s1_reg, xd_s2_reg;
  logic [15:0] ma, mb;
  logic mword;
  logic [31:0] prod;
  logic m_ovf, m_neg, m_zero;
  logic [7:0] op, opnd, or_a, or_b, or_r;
  logic is_port, bin_pfx;
  logic [4:0] dnum;

  assign op = instr_i.opcode;
  assign opnd = instr_i.operand;
  // Escape prefix means the extended map in binary mode only
  assign bin_pfx = instr_i.prefixed & ~source_mode_i;

  mmx_mul u_mul (
    .a_i(ma),
    .b_i(mb),
    .word_i(mword),
    .prod_o(prod),
    .ovf_o(m_ovf),
    .neg_o(m_neg),
    .zero_o(m_zero)
  );

  always_comb begin
    // RQ8 unsigned register operands
    mword = (op == `MMX_OP_MULW);
    ma = (op == `MMX_OP_MULAB) ? {8'h00, acc_i}
       : (mword ? dst_val_i : {8'h00, dst_val_i[7:0]});
    mb = (op == `MMX_OP_MULAB) ? {8'h00, b_i}
       : (mword ? src_val_i : {8'h00, src_val_i[7:0]});
    is_port = ((opnd & `MMX_PORT_MASK) == `MMX_PORT_LO)
            && (opnd <= `MMX_PORT_HI);
    dnum = {1'b0, instr_i.operand[7:4]};
  end

  always_comb begin
    // Flags follow the core while idle so a start sees current values
    flags_next = (state_reg == MMX_IDLE) ? flags_i : flags_reg;
    xbus_next = xbus_reg;
    wr0_data_next = wr0_data_reg;
    wr0_idx_next = wr0_idx_reg;
    wr1_data_next = wr1_data_reg;
    wr1_idx_next = wr1_idx_reg;
    wr_en_next = 2'b00;
    wr_word_next = wr_word_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    dir_next = dir_reg;
    acc_we_next = 1'b0;
    b_we_next = 1'b0;
    dir_we_next = 1'b0;
    pc_next = 1'b0;
    done_next = 1'b0;
    ill_next = 1'b0;
    or_a = acc_i;
    or_b = 8'h00;
    or_r = 8'h00;
    len = `MMX_ST_NOP;
    // Source for or: latch for ports so read-modify-write keeps outputs
    unique case (op)
      // RQ21 port latch source
      `MMX_OP_OR_DA: begin
        or_a = is_port ? port_latch_i : dst_val_i[7:0];
        or_b = acc_i;
      end
      `MMX_OP_OR_DI: begin
        or_a = is_port ? port_latch_i : dst_val_i[7:0];
        or_b = src_val_i[7:0];
      end
      default: begin
        or_a = bin_pfx || op == `MMX_OP_OR_RR ? dst_val_i[7:0] : acc_i;
        or_b = src_val_i[7:0];
      end
    endcase
    // RQ19 bitwise or
    or_r = or_a | or_b;
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      MMX_IDLE: begin
        xbus_next.oe = 1'b0;
        xbus_next.wr = 1'b0;
        xbus_next.rd = 1'b0;
        if (start_i) begin
          state_next = MMX_EXEC;
          if (op == `MMX_OP_NOP) begin
            // RQ17 one state, pc only
            len = `MMX_ST_NOP;
          end else if (op == `MMX_OP_ZERO_EXTEND_MOVE && instr_i.prefixed
                       == ~source_mode_i) begin
            // RQ7 zero extend timing
            len = source_mode_i ? `MMX_ST_ZERO_EXTEND_MOVE_SRC : `MMX_ST_ZERO_EXTEND_MOVE_BIN;
            // RQ6 clear upper byte
            wr1_data_next = {8'h00, src_val_i[7:0]};
            wr1_idx_next = dnum;
            wr_word_next = 1'b1;
          end else if (op == `MMX_OP_XRD_DP || op == `MMX_OP_XWR_DP
                       || op[7:1] == `MMX_OP_XRD_RI
                       || op[7:1] == `MMX_OP_XWR_RI) begin
            // RQ5 indirect load 3 states
            len = op[1] ? `MMX_ST_XRI : `MMX_ST_XDP;
            // Address phase first: lanes carry address, no strobe yet
            xbus_next.oe = 1'b1;
            // RQ1 RQ2 address selection
            xbus_next.port_zero = op[1] ? ind_reg_i
                                        : data_pointer_i[7:0];
            xbus_next.port_two = op[1] ? port_two_latch_i
                                       : data_pointer_i[15:8];
          end else if (op == `MMX_OP_MULR || op == `MMX_OP_MULW
                       || op == `MMX_OP_MULAB) begin
            // RQ15 multiply timing
            len = op == `MMX_OP_MULAB ? `MMX_ST_MULAB
                : op == `MMX_OP_MULR
                  ? (source_mode_i ? `MMX_ST_MULR_SRC : `MMX_ST_MULR_BIN)
                  : (source_mode_i ? `MMX_ST_MULW_SRC : `MMX_ST_MULW_BIN);
            // RQ13 carry cleared
            flags_next.carry_flag = 1'b0;
            flags_next.overflow_flag = m_ovf;
            flags_next.neg = m_neg;
            flags_next.zero = m_zero;
            if (op == `MMX_OP_MULAB) begin
              // RQ16 accumulator and b
              acc_next = prod[7:0];
              b_next = prod[15:8];
            end else if (!mword) begin
              // RQ10 byte pairing
              wr0_data_next = prod[7:0];
              wr0_idx_next = {dnum[4:1], 1'b0};
              wr1_data_next = {8'h00, prod[15:8]};
              wr1_idx_next = {dnum[4:1], 1'b1};
              wr_word_next = 1'b0;
            end else begin
              // RQ12 word pairing
              wr1_data_next = prod[15:0];
              wr1_idx_next = {dnum[3:1], 2'b00};
              wr0_data_next = prod[23:16];
              wr0_idx_next = {dnum[3:1], 2'b10};
              wr_word_next = 1'b1;
            end
          end else if (op[7:4] == 4'h4) begin
            // RQ20 destination by form
            len = (op[3:1] != 3'b001 && is_port) ? `MMX_ST_PORT
                                                 : `MMX_ST_OR;
            // RQ22 only sign and zero
            flags_next.neg = or_r[7];
            flags_next.zero = (or_r == 8'h00);
            if (op[3:1] == 3'b001) begin
              // RQ18 port write four states
              len = is_port ? `MMX_ST_PORT : `MMX_ST_OR;
              dir_next = or_r;
            end else if (op == `MMX_OP_OR_RR || bin_pfx) begin
              wr0_data_next = or_r;
              wr0_idx_next = dnum;
              wr_word_next = 1'b0;
            end else begin
              acc_next = or_r;
            end
          end else begin
            ill_next = 1'b1;
            state_next = MMX_DONE;
          end
          cnt_next = len;
        end
      end
      MMX_EXEC: begin
        cnt_next = cnt_reg - 4'h1;
        if (xbus_reg.oe) begin
          // RQ3 RQ4 data multiplexing
          xbus_next.rd = ~op[4];
          xbus_next.wr = op[4];
          // Reads keep the address on the lanes
          if (op[4] && page_mode_i) begin
            xbus_next.port_two = acc_i;
          end else if (op[4]) begin
            xbus_next.port_zero = acc_i;
          end
        end
        if (cnt_reg == 4'h1) begin
          state_next = MMX_DONE;
          pc_next = 1'b1;
          done_next = 1'b1;
          if (xbus_reg.rd) begin
            acc_next = xd_s2_reg;
            acc_we_next = 1'b1;
          end else if (op == `MMX_OP_MULAB || op == `MMX_OP_OR_AI
                       || op == `MMX_OP_OR_AD || op[7:1] == `MMX_OP_OR_AR
                       || (op[7:3] == `MMX_OP_OR_ARN && !bin_pfx)) begin
            acc_we_next = 1'b1;
            b_we_next = (op == `MMX_OP_MULAB);
          end else if (op[7:1] == 7'h21) begin
            dir_we_next = 1'b1;
          end else if (op[7:4] == 4'h4 || op == `MMX_OP_MULR) begin
            wr_en_next = op == `MMX_OP_MULR ? 2'b11 : 2'b01;
          end else if (op == `MMX_OP_ZERO_EXTEND_MOVE) begin
            wr_en_next = 2'b10;
          end else if (op == `MMX_OP_MULW) begin
            wr_en_next = 2'b11;
          end
        end
      end
      MMX_DONE: begin
        state_next = MMX_IDLE;
        xbus_next.oe = 1'b0;
        xbus_next.wr = 1'b0;
        xbus_next.rd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    xd_s1_reg <= xdata_pin_i;
    xd_s2_reg <= xd_s1_reg;
    if (rst_i) begin
      state_reg <= MMX_IDLE;
      cnt_reg <= 4'h0;
      flags_reg <= '0;
      xbus_reg <= '0;
      wr0_data_reg <= 8'h00;
      wr0_idx_reg <= 5'h00;
      wr1_data_reg <= 16'h0000;
      wr1_idx_reg <= 5'h00;
      wr_en_reg <= 2'b00;
      wr_word_reg <= 1'b0;
      acc_reg <= 8'h00;
      b_reg <= 8'h00;
      dir_reg <= 8'h00;
      acc_we_reg <= 1'b0;
      b_we_reg <= 1'b0;
      dir_we_reg <= 1'b0;
      pc_reg <= 1'b0;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      flags_reg <= flags_next;
      xbus_reg <= xbus_next;
      wr0_data_reg <= wr0_data_next;
      wr0_idx_reg <= wr0_idx_next;
      wr1_data_reg <= wr1_data_next;
      wr1_idx_reg <= wr1_idx_next;
      wr_en_reg <= wr_en_next;
      wr_word_reg <= wr_word_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      dir_reg <= dir_next;
      acc_we_reg <= acc_we_next;
      b_we_reg <= b_we_next;
      dir_we_reg <= dir_we_next;
      pc_reg <= pc_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
    end
  end

  assign flags_o = flags_reg;
  assign xbus_o = xbus_reg;
  assign wr0_data_o = wr0_data_reg;
  assign wr0_idx_o = wr0_idx_reg;
  assign wr1_data_o = wr1_data_reg;
  assign wr1_idx_o = wr1_idx_reg;
  assign wr_en_o = wr_en_reg;
  assign wr_word_o = wr_word_reg;
  assign acc_o = acc_reg;
  assign acc_we_o = acc_we_reg;
  assign b_o = b_reg;
  assign b_we_o = b_we_reg;
  assign dir_o = dir_reg;
  assign dir_we_o = dir_we_reg;
  assign pc_inc_o = pc_reg;
  assign busy_o = (state_reg != MMX_IDLE);
  assign done_o = done_reg;
  assign illegal_o = ill_reg;

  // Assertions
  carry_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ13
    (state_reg == MMX_IDLE && start_i && op == `MMX_OP_MULAB)
    |=> !flags_o.carry_flag)
    else $error("multiply left carry set");
  nop_len_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ17
    (state_reg == MMX_IDLE && start_i && op == `MMX_OP_NOP)
    |=> ##1 done_o && pc_inc_o)
    else $error("no-op not one state");
  xri_len_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ5
    (state_reg == MMX_IDLE && start_i && op[7:1] == `MMX_OP_XRD_RI)
    |=> !done_o [*3] ##1 done_o)
    else $error("indirect load not three states");
  short_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ1
    (state_reg == MMX_IDLE && start_i && op[7:1] == `MMX_OP_XRD_RI)
    |=> xbus_o.port_zero == $past(ind_reg_i))
    else $error("short address wrong");
  long_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
    (state_reg == MMX_IDLE && start_i && op == `MMX_OP_XRD_DP)
    |=> xbus_o.port_two == $past(data_pointer_i[15:8]))
    else $error("long address wrong");
  or_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ22
    (state_reg == MMX_IDLE && start_i && op == `MMX_OP_OR_AI)
    |=> flags_o.overflow_flag == $past(flags_i.overflow_flag))
    else $error("or touched overflow");
  mulab_ovf_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ16
    (state_reg == MMX_IDLE && start_i && op == `MMX_OP_MULAB)
    |=> flags_o.overflow_flag == (b_o != 8'h00))
    else $error("overflow mismatch");
  zero_extend_move_hi_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
    wr_en_o == 2'b10 |-> wr1_data_o[15:8] == 8'h00)
    else $error("upper byte not cleared");
  mul_cv: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    start_i && state_reg == MMX_IDLE && op == `MMX_OP_MULR);
  or_cv: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    dir_we_o);
  xmv_cv: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    xbus_o.wr);
endmodule

// File: verification/mmx_xram.sv
// Purpose: external data memory on the multiplexed port lanes
// Assumes: address phase shows oe high with rd and wr low
// Notes: a released read lane shows the inverse of its last byte
`timescale 1ns/1ps
module mmx_xram
  import mmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic page_mode_i,
  input wire mmx_xbus_s xbus_i,
  output logic [7:0] xdata_pin_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_reg = 16'h0000;
  logic [7:0] last_reg = 8'h00;

  always @(posedge sys_clk_i) begin
    if (xbus_i.oe && !xbus_i.rd && !xbus_i.wr) begin
      addr_reg <= {xbus_i.port_two, xbus_i.port_zero};
    end
    if (xbus_i.wr) begin
      mem[addr_reg] <= page_mode_i ? xbus_i.port_two : xbus_i.port_zero;
    end
    if (xbus_i.rd) begin
      last_reg <= mem[addr_reg];
    end
  end

  // Read data follows the address lanes; inverse when released
  assign xdata_pin_o = (xbus_i.oe && !xbus_i.wr)
                     ? mem[{xbus_i.port_two, xbus_i.port_zero}] : ~last_reg;
endmodule

// File: verification/move_multiply_or_execute_test.sv
// Purpose: self-checking bench for the execution block
// Assumes: one state per clock, start taken only in idle
// Notes: expected values are worked out here from the operands
`timescale 1ns/1ps
`include "mmx_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module move_multiply_or_execute_test;
  import mmx_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic source_mode_i = 1'b0;
  logic page_mode_i = 1'b0;
  mmx_instr_s instr_i;
  logic [15:0] dst_val_i, src_val_i, data_pointer_i, wr1_data_o;
  logic [7:0] acc_i, b_i, ind_reg_i, port_two_latch_i, port_latch_i;
  logic [7:0] xdata_pin_i, wr0_data_o, acc_o, b_o, dir_o, d, r;
  mmx_flags_s flags_i, flags_o;
  mmx_xbus_s xbus_o;
  logic [4:0] wr0_idx_o, wr1_idx_o, lo;
  logic [1:0] wr_en_o, s_wr;
  logic wr_word_o, acc_we_o, b_we_o, dir_we_o, pc_inc_o;
  logic busy_o, done_o, illegal_o, w;
  logic s_acc, s_b, s_dir, s_pc, s_a;
  logic chk_hi = 1'b0;
  logic [15:0] exp_a = 16'h0000;
  logic [31:0] p;
  logic [25:0] got;
  logic [3:0] fo, fe;
  int seed = 32'h49737bf5;
  int n_fail = 0;
  int checks = 0;
  int took;

  assign fo = {flags_o.carry_flag, flags_o.overflow_flag, flags_o.neg,
               flags_o.zero};
  always #12.5 sys_clk_i = ~sys_clk_i;

  mmx_core i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i),
    .instr_i(instr_i), .source_mode_i(source_mode_i),
    .page_mode_i(page_mode_i), .dst_val_i(dst_val_i),
    .src_val_i(src_val_i), .acc_i(acc_i), .b_i(b_i), .ind_reg_i(ind_reg_i),
    .data_pointer_i(data_pointer_i), .port_two_latch_i(port_two_latch_i),
    .port_latch_i(port_latch_i), .xdata_pin_i(xdata_pin_i),
    .flags_i(flags_i), .flags_o(flags_o), .xbus_o(xbus_o),
    .wr0_data_o(wr0_data_o), .wr0_idx_o(wr0_idx_o),
    .wr1_data_o(wr1_data_o), .wr1_idx_o(wr1_idx_o), .wr_en_o(wr_en_o),
    .wr_word_o(wr_word_o), .acc_o(acc_o), .acc_we_o(acc_we_o), .b_o(b_o),
    .b_we_o(b_we_o), .dir_o(dir_o), .dir_we_o(dir_we_o),
    .pc_inc_o(pc_inc_o), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o)
  );

  mmx_xram i_ram (
    .sys_clk_i(sys_clk_i), .page_mode_i(page_mode_i), .xbus_i(xbus_o),
    .xdata_pin_o(xdata_pin_i)
  );

  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic randin();
    dst_val_i = 16'($random(seed));
    src_val_i = 16'($random(seed));
    data_pointer_i = 16'($random(seed));
    acc_i = 8'($random(seed));
    b_i = 8'($random(seed));
    ind_reg_i = 8'($random(seed));
    port_two_latch_i = 8'($random(seed));
    port_latch_i = 8'($random(seed));
    flags_i = 5'($random(seed));
    instr_i = 17'($random(seed));
  endtask

  // Counts edges from the taking edge up to the done pulse
  task automatic run();
    {s_acc, s_b, s_dir, s_pc, s_a, s_wr} = 7'h00;
    took = 0;
    start_i = 1'b1;
    do begin
      @(posedge sys_clk_i);
      #1;
      start_i = 1'b0;
      took++;
      s_wr = s_wr | wr_en_o;
      s_acc = s_acc | acc_we_o;
      s_b = s_b | b_we_o;
      s_dir = s_dir | dir_we_o;
      s_pc = s_pc | pc_inc_o;
      if (xbus_o.oe === 1'b1 && xbus_o.port_zero === exp_a[7:0] &&
          (!chk_hi || xbus_o.port_two === exp_a[15:8])) begin
        s_a = 1'b1;
      end
    end while (done_o !== 1'b1 && took < 40);
    if (took >= 40) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, took, 0);
      results();
    end
    @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    randin();
    repeat (3) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    instr_i.opcode = `MMX_OP_NOP;
    instr_i.prefixed = 1'b0;
    run();
    `CHK(took, 2)
    `CHK({s_pc, s_acc, s_b, s_dir, s_wr}, 6'h20)
    $display("nop done");
    for (int m = 0; m < 2; m++) begin
      randin();
      source_mode_i = m[0];
      instr_i.opcode = `MMX_OP_ZERO_EXTEND_MOVE;
      instr_i.prefixed = !m[0];
      run();
      `CHK(took, 3 - m)
      `CHK({s_wr[1], wr1_data_o}, {1'b1, 8'h00, src_val_i[7:0]})
    end
    $display("zero_extend_move done");
    for (int k = 0; k < 12; k++) begin
      randin();
      w = (k >= 6);
      case (k)
        0: dst_val_i = 16'h0000;
        1: {dst_val_i, src_val_i} = {16'h00ff, 16'h00ff};
        2: {dst_val_i, src_val_i} = {16'h0001, 16'h00ff};
        3: {dst_val_i, src_val_i} = {16'h0010, 16'h0010};
        6: {dst_val_i, src_val_i} = {16'hffff, 16'h0001};
        7: {dst_val_i, src_val_i} = {16'h0100, 16'h0100};
        8: {dst_val_i, src_val_i} = {16'hffff, 16'hffff};
        default: ;
      endcase
      if (!w) begin
        dst_val_i[15:8] = 8'h00;
        src_val_i[15:8] = 8'h00;
      end
      source_mode_i = k[0];
      flags_i.carry_flag = 1'b1;
      instr_i.operand[4] = k[1];
      instr_i.opcode = w ? `MMX_OP_MULW : `MMX_OP_MULR;
      instr_i.prefixed = !k[0];
      p = 32'(dst_val_i) * 32'(src_val_i);
      fe = {1'b0, p > (w ? 32'h0000_ffff : 32'h0000_00ff),
            w ? p[31] : p[15], p == 32'h0000_0000};
      lo = {1'b0, instr_i.operand[7:5], 1'b0};
      run();
      `CHK(took, (w ? 12 : 7) - k[0])
      `CHK(fo, fe)
      if (wr0_idx_o === lo) begin
        got = {wr0_data_o, wr1_data_o[7:0], wr0_idx_o, wr1_idx_o};
      end else begin
        got = {wr1_data_o[7:0], wr0_data_o, wr1_idx_o, wr0_idx_o};
      end
      if (!w) `CHK(got, {p[7:0], p[15:8], lo, lo | 5'h01})
      if (w) `CHK({wr0_data_o, wr1_data_o}, p[23:0])
    end
    $display("mul done");
    for (int k = 0; k < 2; k++) begin
      randin();
      if (k == 0) begin
        acc_i = 8'h50;
        b_i = 8'ha0;
      end
      instr_i.opcode = `MMX_OP_MULAB;
      instr_i.prefixed = 1'b0;
      p = 32'(acc_i) * 32'(b_i);
      run();
      `CHK(took, 6)
      `CHK({b_o, acc_o, s_acc, s_b}, {p[15:0], 2'h3})
      `CHK(fo[3:2], {1'b0, p > 32'h0000_00ff})
    end
    $display("mulab done");
    for (int j = 0; j < 3; j++) begin
      randin();
      dst_val_i[15:8] = 8'h00;
      instr_i.opcode = (j == 2) ? `MMX_OP_OR_AI : `MMX_OP_OR_DA;
      if (j < 2) instr_i.operand = j[0] ? 8'h90 : 8'h30;
      src_val_i = {8'h00, instr_i.operand};
      instr_i.prefixed = 1'b0;
      r = (j == 1) ? port_latch_i : dst_val_i[7:0];
      r = acc_i | ((j == 2) ? instr_i.operand : r);
      run();
      `CHK(took, (j == 1) ? 5 : 3)
      `CHK((j == 2) ? acc_o : dir_o, r)
      `CHK(flags_o, {flags_i[4:2], r[7], r == 8'h00})
    end
    $display("or done");
    for (int j = 0; j < 4; j++) begin
      randin();
      page_mode_i = j[1];
      source_mode_i = j[1] ^ j[0];
      chk_hi = j[0];
      d = acc_i;
      exp_a = j[0] ? data_pointer_i : {port_two_latch_i, ind_reg_i};
      instr_i.opcode = j[0] ? `MMX_OP_XWR_DP : {`MMX_OP_XWR_RI, 1'b0};
      instr_i.prefixed = !j[0] && source_mode_i;
      run();
      `CHK(s_a, 1'b1)
      acc_i = ~d;
      instr_i.opcode = j[0] ? `MMX_OP_XRD_DP : {`MMX_OP_XRD_RI, 1'b1};
      run();
      `CHK(took, j[0] ? 5 : 4)
      `CHK({s_a, s_acc, acc_o}, {2'h3, d})
    end
    $display("xmove done");
    results();
  end
endmodule
